/* File: design/complementary_waveform_control.sv */
`include "cwu_params.svh"
`timescale 1ns/100ps
`default_nettype none

module complementary_waveform_control #(
   parameter int DB_W = 6                     // Dead-band count width.
) (
   // Clock and reset.
   input  wire logic              mclk_i,
   input  wire logic              resetn_i,
   // Register port.
   input  wire cwu_pkg::reg_req_t req_i,
   output logic [7:0]             rdata_o,
   // Data input candidates.
   input  wire cwu_pkg::sources_t src_i,
   // Driver outputs A to D in bits 0 to 3.
   output logic [3:0]             wave_o,
   // Active dead-band counts for the dead-band counters.
   output logic [DB_W-1:0]        db_rise_o,
   output logic [DB_W-1:0]        db_fall_o,
   // Clock source choice for the clock mux, high for the fast oscillator.
   output logic                   clk_sel_o
);

   // Software visible registers.
   logic              en_reg, en_next;          // Module enable.
   logic              ld_reg, ld_next;          // Buffer load request.
   cwu_pkg::mode_t    mode_reg, mode_next;      // Output mode.
   logic [3:0]        pol_reg, pol_next;        // Output polarity.
   logic              cs_reg, cs_next;          // Clock source select.
   logic [4:0]        sel_reg, sel_next;        // Input source field.
   logic [7:0]        str_reg, str_next;        // Override data high, steering enable low.
   logic [DB_W-1:0]   dbr_reg, dbr_next;        // Rising count, written side.
   logic [DB_W-1:0]   dbf_reg, dbf_next;        // Falling count, written side.
   logic [DB_W-1:0]   dbr_act_reg, dbr_act_next;
   logic [DB_W-1:0]   dbf_act_reg, dbf_act_next;
   logic [7:0]        rdata_reg, rdata_next;
   // Generator state.
   cwu_pkg::load_state_t lst_reg, lst_next;     // Load request progress.
   logic              din_reg, din_next;        // Sampled data input.
   logic              dprev_reg, dprev_next;    // Previous sample for edges.
   logic              phase_reg, phase_next;    // Push-pull phase.
   logic [3:0]        steer_act_reg, steer_act_next;
   logic [3:0]        wave_reg, wave_next;
   logic              sel_data;                 // Chosen source, combinational.
   logic              rise, fall;

   // Source selection lives in its own small module.
   input_source_mux u_mux (
      .src_i  (src_i),
      .sel_i  (sel_reg),
      .data_o (sel_data)
   );

   // Address match helper used by both the write and read paths.
   function automatic logic hit(input cwu_pkg::reg_req_t r, input logic [15:0] ofs);
      return r.addr == ofs;
   endfunction

   assign rise = din_reg & ~dprev_reg;
   assign fall = ~din_reg & dprev_reg;

   // Register writes, the load request sequence and buffer transfers.
   always_comb begin
      en_next      = en_reg;
      ld_next      = ld_reg;
      mode_next    = mode_reg;
      pol_next     = pol_reg;
      cs_next      = cs_reg;
      sel_next     = sel_reg;
      str_next     = str_reg;
      dbr_next     = dbr_reg;
      dbf_next     = dbf_reg;
      dbr_act_next = dbr_act_reg;
      dbf_act_next = dbf_act_reg;
      lst_next     = lst_reg;
      if (req_i.wr) begin
         if (hit(req_i, `CWU_OFS_CON0)) begin
            en_next   = req_i.wdata[`CWU_EN_BIT];
            mode_next = cwu_pkg::mode_t'(req_i.wdata[2:0]);
            if (req_i.wdata[`CWU_LD_BIT] && en_reg) begin
               ld_next  = 1'b1;
               lst_next = cwu_pkg::LOAD_WAIT_FALL;
            end
            // A written zero withdraws a pending request.
            else if (!req_i.wdata[`CWU_LD_BIT]) begin
               ld_next  = 1'b0;
               lst_next = cwu_pkg::LOAD_IDLE;
            end
         end
         if (hit(req_i, `CWU_OFS_CON1)) pol_next = req_i.wdata[3:0];
         if (hit(req_i, `CWU_OFS_CLK))  cs_next  = req_i.wdata[`CWU_CS_BIT];
         if (hit(req_i, `CWU_OFS_ISM))  sel_next = req_i.wdata[4:0];
         if (hit(req_i, `CWU_OFS_STR))  str_next = req_i.wdata;
         if (hit(req_i, `CWU_OFS_DBR))  dbr_next = req_i.wdata[DB_W-1:0];
         if (hit(req_i, `CWU_OFS_DBF))  dbf_next = req_i.wdata[DB_W-1:0];
      end
      if (!en_reg) begin
         dbr_act_next = dbr_next;
         dbf_act_next = dbf_next;
         ld_next      = 1'b0;
         lst_next     = cwu_pkg::LOAD_IDLE;
      end else begin
         case (lst_reg)
            cwu_pkg::LOAD_IDLE: begin
               lst_next = lst_next;
            end
            cwu_pkg::LOAD_WAIT_FALL: begin
               if (fall && lst_next != cwu_pkg::LOAD_IDLE) lst_next = cwu_pkg::LOAD_WAIT_RISE;
            end
            cwu_pkg::LOAD_WAIT_RISE: begin
               if (rise) begin
                  dbr_act_next = dbr_reg;
                  dbf_act_next = dbf_reg;
                  // A request set in this very cycle survives the transfer, so the set wins.
                  if (lst_next == cwu_pkg::LOAD_WAIT_RISE) begin
                     ld_next  = 1'b0;
                     lst_next = cwu_pkg::LOAD_IDLE;
                  end
               end
            end
            default: begin
               lst_next = cwu_pkg::LOAD_IDLE;
            end
         endcase
      end
   end

   // Read path: data stand only in the cycle after the strobe; unmapped reads zero.
   always_comb begin
      rdata_next = 8'h00;
      if (req_i.rd) begin
         if (hit(req_i, `CWU_OFS_CON0)) rdata_next = {en_reg, ld_reg, 3'h0, mode_reg};
         if (hit(req_i, `CWU_OFS_CON1)) rdata_next = {2'h0, din_reg, 1'h0, pol_reg};
         if (hit(req_i, `CWU_OFS_CLK))  rdata_next = {7'h00, cs_reg};
         if (hit(req_i, `CWU_OFS_ISM))  rdata_next = {3'h0, sel_reg};
         if (hit(req_i, `CWU_OFS_STR))  rdata_next = str_reg;
         if (hit(req_i, `CWU_OFS_DBR))  rdata_next = {{(8-DB_W){1'b0}}, dbr_reg};
         if (hit(req_i, `CWU_OFS_DBF))  rdata_next = {{(8-DB_W){1'b0}}, dbf_reg};
      end
   end

   // Waveform generation. The input is sampled once, so outputs lag it by two
   // cycles; this keeps every output on a flip-flop at the cost of latency.
   always_comb begin
      logic [3:0] raw;
      raw            = 4'h0;
      din_next       = sel_data;
      dprev_next     = din_reg;
      phase_next     = phase_reg;
      steer_act_next = steer_act_reg;
      wave_next      = pol_reg;
      if (en_reg) begin
         case (mode_reg)
            cwu_pkg::MODE_ASYNC_STEER,
            cwu_pkg::MODE_SYNC_STEER: begin
               if (mode_reg == cwu_pkg::MODE_ASYNC_STEER) steer_act_next = str_reg[3:0];
               else if (rise) steer_act_next = str_reg[3:0];
               raw = {4{din_reg}};
            end
            cwu_pkg::MODE_FWD_BRIDGE:  raw = {din_reg, 1'b0, 1'b0, 1'b1};
            cwu_pkg::MODE_REV_BRIDGE:  raw = {1'b0, 1'b1, din_reg, 1'b0};
            cwu_pkg::MODE_HALF_BRIDGE: raw = {~din_reg, din_reg, ~din_reg, din_reg};
            cwu_pkg::MODE_PUSH_PULL: begin
               if (rise) phase_next = ~phase_reg;
               // The new phase is used at once, so a pulse never starts on the old pair.
               raw = {din_reg & ~phase_next, din_reg & phase_next, din_reg & ~phase_next, din_reg & phase_next};
            end
            default: raw = 4'h0;
         endcase
         wave_next = raw ^ pol_reg;
         if (mode_reg == cwu_pkg::MODE_ASYNC_STEER || mode_reg == cwu_pkg::MODE_SYNC_STEER) begin
            for (int i = 0; i < 4; i++) begin
               if (!steer_act_next[i]) wave_next[i] = str_reg[4+i];
            end
         end
      end
   end

   // Every register of the block.
   always_ff @(posedge mclk_i) begin
      if (!resetn_i) begin
         en_reg        <= 1'b0;
         ld_reg        <= 1'b0;
         mode_reg      <= cwu_pkg::MODE_ASYNC_STEER;
         pol_reg       <= 4'h0;
         cs_reg        <= 1'b0;
         sel_reg       <= `CWU_RST_SEL;
         str_reg       <= `CWU_RST_BYTE;
         dbr_reg       <= `CWU_RST_DB;
         dbf_reg       <= `CWU_RST_DB;
         dbr_act_reg   <= `CWU_RST_DB;
         dbf_act_reg   <= `CWU_RST_DB;
         rdata_reg     <= `CWU_RST_BYTE;
         lst_reg       <= cwu_pkg::LOAD_IDLE;
         din_reg       <= 1'b0;
         dprev_reg     <= 1'b0;
         phase_reg     <= 1'b0;
         steer_act_reg <= 4'h0;
         wave_reg      <= 4'h0;
      end else begin
         en_reg        <= en_next;
         ld_reg        <= ld_next;
         mode_reg      <= mode_next;
         pol_reg       <= pol_next;
         cs_reg        <= cs_next;
         sel_reg       <= sel_next;
         str_reg       <= str_next;
         dbr_reg       <= dbr_next;
         dbf_reg       <= dbf_next;
         dbr_act_reg   <= dbr_act_next;
         dbf_act_reg   <= dbf_act_next;
         rdata_reg     <= rdata_next;
         lst_reg       <= lst_next;
         din_reg       <= din_next;
         dprev_reg     <= dprev_next;
         phase_reg     <= phase_next;
         steer_act_reg <= steer_act_next;
         wave_reg      <= wave_next;
      end
   end

   assign rdata_o   = rdata_reg;
   assign wave_o    = wave_reg;
   assign db_rise_o = dbr_act_reg;
   assign db_fall_o = dbf_act_reg;
   assign clk_sel_o = cs_reg;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   wr_con0_ld_a:    assert property ((req_i.wr && hit(req_i, `CWU_OFS_CON0) && !en_reg) |=> !ld_reg)
      else $error("Load request accepted while disabled.");
   off_idle_out_a:  assert property (!en_reg |=> wave_o == $past(pol_reg))
      else $error("Outputs active while disabled.");
   // A request written in the transfer cycle stays pending, so it is left out here.
   load_xfer_a:     assert property ((en_reg && lst_reg == cwu_pkg::LOAD_WAIT_RISE && rise
      && !(req_i.wr && hit(req_i, `CWU_OFS_CON0) && req_i.wdata[`CWU_LD_BIT]))
      |=> (db_fall_o == $past(dbf_reg)) && (db_rise_o == $past(dbr_reg)) && !ld_reg)
      else $error("Buffers not transferred on rising edge.");
   load_hold_a:     assert property ((en_reg && lst_reg == cwu_pkg::LOAD_WAIT_FALL) |=> $stable(db_fall_o))
      else $error("Buffers changed before falling edge.");
   dis_db_load_a:   assert property ((!en_reg && req_i.wr && hit(req_i, `CWU_OFS_DBF))
      |=> db_fall_o == $past(req_i.wdata[DB_W-1:0]))
      else $error("Disabled count write not loaded.");
   half_bridge_a:   assert property ((en_reg && mode_reg == cwu_pkg::MODE_HALF_BRIDGE)
      |=> wave_o == ({~$past(din_reg), $past(din_reg), ~$past(din_reg), $past(din_reg)} ^ $past(pol_reg)))
      else $error("Half bridge outputs wrong.");
   in_readback_a:   assert property ((req_i.rd && hit(req_i, `CWU_OFS_CON1))
      |=> rdata_o[`CWU_IN_BIT] == $past(din_reg))
      else $error("Input level readback wrong.");
   clk_sel_a:       assert property ((req_i.wr && hit(req_i, `CWU_OFS_CLK))
      |=> clk_sel_o == $past(req_i.wdata[`CWU_CS_BIT]))
      else $error("Clock select not taken.");
   steer_ovr_a:     assert property ((en_reg && mode_reg == cwu_pkg::MODE_ASYNC_STEER && !str_reg[0])
      |=> wave_o[0] == $past(str_reg[4]))
      else $error("Override data not driven.");
   rsvd_mode_a:     assert property ((en_reg && mode_reg == cwu_pkg::MODE_RSVD_6) |=> wave_o == $past(pol_reg))
      else $error("Reserved mode drove outputs.");
   // The selector output is checked on the block clock, where the field settles.
   reserved_sel_low_a: assert property (((sel_reg > 5'h11) || ((sel_reg > 5'h06) && (sel_reg < 5'h0B)))
      |-> !sel_data)
      else $error("Reserved selection did not read low.");

   load_done_c:  cover property (en_reg && lst_reg == cwu_pkg::LOAD_WAIT_RISE && rise);
   push_pull_c:  cover property (en_reg && mode_reg == cwu_pkg::MODE_PUSH_PULL && rise ##[1:40] rise);
   sync_steer_c: cover property (en_reg && mode_reg == cwu_pkg::MODE_SYNC_STEER && rise);

endmodule // complementary_waveform_control

`default_nettype wire

/* File: design/cwu_params.svh */
`ifndef CWU_PARAMS_SVH
`define CWU_PARAMS_SVH

// Register byte offsets on the register port.
`define CWU_OFS_CLK        16'h060C
`define CWU_OFS_ISM        16'h060D
`define CWU_OFS_DBR        16'h060E
`define CWU_OFS_DBF        16'h060F
`define CWU_OFS_CON0       16'h0610
`define CWU_OFS_CON1       16'h0611
`define CWU_OFS_STR        16'h0614

// Field positions.
`define CWU_EN_BIT         7
`define CWU_LD_BIT         6
`define CWU_IN_BIT         5
`define CWU_CS_BIT         0

// Reset values.
`define CWU_RST_BYTE       8'h00
`define CWU_RST_DB         6'h00
`define CWU_RST_SEL        5'h00

`endif

/* File: design/cwu_pkg.sv */
package cwu_pkg;

   // Output operating modes, encoded as in the mode field.
   typedef enum logic [2:0] {
      MODE_ASYNC_STEER = 3'h0,
      MODE_SYNC_STEER  = 3'h1,
      MODE_FWD_BRIDGE  = 3'h2,
      MODE_REV_BRIDGE  = 3'h3,
      MODE_HALF_BRIDGE = 3'h4,
      MODE_PUSH_PULL   = 3'h5,
      MODE_RSVD_6      = 3'h6,
      MODE_RSVD_7      = 3'h7
   } mode_t;

   // Progress of a buffer load request.
   typedef enum logic [1:0] {
      LOAD_IDLE,
      LOAD_WAIT_FALL,
      LOAD_WAIT_RISE
   } load_state_t;

   // Candidate data input sources.
   typedef struct packed {
      logic       remappable_input_pin;
      logic [1:0] capture_compare_output;
      logic [3:0] pwm_slice_output;
      logic       oscillator_output;
      logic [1:0] comparator_output;
      logic [3:0] logic_cell_output;
   } sources_t;

   // Register port request.
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

endpackage

/* File: design/input_source_mux.sv */
`timescale 1ns/100ps
`default_nettype none

module input_source_mux (
   // Candidate sources.
   input  wire cwu_pkg::sources_t src_i,
   // Selection field.
   input  wire logic [4:0]        sel_i,
   // Chosen data input.
   output logic                   data_o
);

   // Pick one source; any reserved code yields a constant low level.
   function automatic logic pick(input cwu_pkg::sources_t s, input logic [4:0] code);
      logic r;
      r = 1'b0;
      case (code)
         5'h00:   r = s.remappable_input_pin;
         5'h01:   r = s.capture_compare_output[0];
         5'h02:   r = s.capture_compare_output[1];
         5'h03:   r = s.pwm_slice_output[0];
         5'h04:   r = s.pwm_slice_output[1];
         5'h05:   r = s.pwm_slice_output[2];
         5'h06:   r = s.pwm_slice_output[3];
         5'h0B:   r = s.oscillator_output;
         5'h0C:   r = s.comparator_output[0];
         5'h0D:   r = s.comparator_output[1];
         5'h0E:   r = s.logic_cell_output[0];
         5'h0F:   r = s.logic_cell_output[1];
         5'h10:   r = s.logic_cell_output[2];
         5'h11:   r = s.logic_cell_output[3];
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // The selection itself.
   // source code decode.
   always_comb begin
      data_o = pick(src_i, sel_i);
   end

endmodule // input_source_mux

`default_nettype wire

/* File: verif/gate_driver_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Stand-in for the external gate drivers. Each switch follows its drive
// level one clock later, like the propagation delay of a real driver.
module gate_driver_model (
   // Clock and reset.
   input  wire logic       mclk_i,
   input  wire logic       resetn_i,
   // Drive levels from the generator.
   input  wire logic [3:0] drive_i,
   // Switch states seen at the power stage.
   output logic [3:0]      gate_o
);
   logic [3:0] gate_next;  // Next switch state.

   // Switches are held open during reset, so no stage conducts at power-up.
   always_comb begin
      gate_next = resetn_i ? drive_i : 4'h0;
   end

   // Register the switch state.
   always_ff @(posedge mclk_i) begin
      gate_o <= gate_next;
   end
endmodule // gate_driver_model

`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cwu_params.svh"

module testbench;
   logic              mclk_i;      // Clock, 25 MHz.
   logic              resetn_i;    // Reset, active low.
   cwu_pkg::reg_req_t req;         // Register port request.
   logic [7:0]        rdata;       // Read data.
   cwu_pkg::sources_t src;         // Candidate data inputs.
   logic [3:0]        wave;        // Generator outputs.
   logic [3:0]        gate;        // Power stage switch states.
   logic [5:0]        db_rise;     // Active rising count.
   logic [5:0]        db_fall;     // Active falling count.
   logic              clk_sel;     // Clock source choice.
   int                fail_count;  // Mismatches seen.
   int                n_compared;  // Comparisons made.
   int                cycles;      // Clock cycles run.
   logic [7:0]        rv;          // Last read value.
   logic [3:0]        w1;          // First push-pull phase.
   logic [13:0]       pat;         // Source pattern.
   int                p;           // Selected source bit.
   // Modes with expected outputs for input high and low, polarity 4'h3.
   logic [2:0]        mode_tab [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
   logic [3:0]        hi_tab   [7] = '{4'hC, 4'hC, 4'hA, 4'h5, 4'h6, 4'h3, 4'h3};
   logic [3:0]        lo_tab   [7] = '{4'h3, 4'h3, 4'h2, 4'h7, 4'h9, 4'h3, 4'h3};

   complementary_waveform_control #(.DB_W(6)) i_complementary_waveform_control (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req), .rdata_o(rdata), .src_i(src),
      .wave_o(wave), .db_rise_o(db_rise), .db_fall_o(db_fall), .clk_sel_o(clk_sel));
   gate_driver_model i_gate_driver_model (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .drive_i(wave), .gate_o(gate));

   // Free-running clock.
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle write strobe.
   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_i);
      req.wr <= 1'b0;
   endtask

   // One-cycle read strobe; data is taken in the following cycle only.
   task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_i);
      req.rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   // Drive the remappable pin and let it reach the outputs.
   task automatic drive_d(input logic d);
      @(posedge mclk_i);
      src.remappable_input_pin <= d;
      repeat (4) @(posedge mclk_i);
      #1;
   endtask

   // Bit of the source vector picked by a selector code, -1 when reserved.
   function automatic int src_pos(input int c);
      if (c == 0) return 13;
      if (c <= 2) return 10 + c;
      if (c <= 6) return c + 4;
      if (c == 11) return 6;
      if (c == 12 || c == 13) return c - 8;
      if (c >= 14 && c <= 17) return c - 14;
      return -1;
   endfunction

   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // A hang counts as a mismatch; the full run needs under 2000 cycles.
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         give_verdict();
      end
   end

   initial begin
      req = '0;
      src = '0;
      resetn_i = 1'b0;
      fail_count = 0;
      n_compared = 0;
      cycles = 0;
      repeat (12) @(posedge mclk_i);
      resetn_i <= 1'b1;
      // Reset state, including an unmapped address that must ignore writes.
      check("wave reset", {4'h0, wave}, 8'h00);
      reg_wr(16'h0612, 8'hFF);
      foreach (mode_tab[i]) begin
         reg_rd(i == 6 ? 16'h0612 : 16'h060C + 16'(i), rv);
         check("reset read", rv, 8'h00);
      end
      reg_wr(`CWU_OFS_CLK, 8'hFF);
      reg_rd(`CWU_OFS_CLK, rv);
      check("clock select read", rv, 8'h01);
      check("clock select out", {7'h00, clk_sel}, 8'h01);
      reg_wr(`CWU_OFS_CLK, 8'h00);
      reg_rd(`CWU_OFS_CLK, rv);
      check("clock select off", {7'h00, clk_sel}, 8'h00);
      // Every selector code, with the chosen source low then high.
      for (int c = 0; c < 32; c++) begin
         reg_wr(`CWU_OFS_ISM, 8'(c));
         p = src_pos(c);
         for (int v = 0; v < 2; v++) begin
            pat = (p < 0) ? {14{v[0]}} : (v[0] ? 14'h0001 << p : ~(14'h0001 << p));
            @(posedge mclk_i);
            src <= cwu_pkg::sources_t'(pat);
            repeat (3) @(posedge mclk_i);
            reg_rd(`CWU_OFS_CON1, rv);
            check("input level", rv, {2'b00, (p >= 0) & v[0], 5'h00});
         end
      end
      // Read-only input bit ignores writes; reserved code reads low.
      src <= '1;
      reg_wr(`CWU_OFS_CON1, 8'hFF);
      reg_rd(`CWU_OFS_CON1, rv);
      check("read-only input", rv, 8'h0F);
      check("reserved low", {7'h00, rv[5]}, 8'h00);
      // Disabled generator shows only polarity.
      src <= '0;
      reg_wr(`CWU_OFS_ISM, 8'h00);
      reg_wr(`CWU_OFS_CON0, 8'h02);
      drive_d(1'b1);
      check("disabled wave", {4'h0, wave}, 8'h0F);
      reg_wr(`CWU_OFS_CON1, 8'h03);
      reg_wr(`CWU_OFS_STR, 8'h0F);
      drive_d(1'b0);
      // Each mode but push-pull, input high then low.
      // reserved codes must leave the outputs idle.
      foreach (mode_tab[i]) begin
         reg_wr(`CWU_OFS_CON0, {5'h10, mode_tab[i]});
         drive_d(1'b1);
         check("mode high", {4'h0, wave}, {4'h0, hi_tab[i]});
         drive_d(1'b0);
         check("mode low", {4'h0, wave}, {4'h0, lo_tab[i]});
         reg_rd(`CWU_OFS_CON0, rv);
         check("mode read", rv, {5'h10, mode_tab[i]});
      end
      check("gate follows", {4'h0, gate}, {4'h0, wave});
      // Push-pull alternates its pair on successive input pulses.
      reg_wr(`CWU_OFS_CON1, 8'h00);
      reg_wr(`CWU_OFS_CON0, 8'h85);
      drive_d(1'b1);
      w1 = wave;
      check("push-pull phase", {7'h00, w1 == 4'h5 || w1 == 4'hA}, 8'h01);
      drive_d(1'b0);
      check("push-pull low", {4'h0, wave}, 8'h00);
      drive_d(1'b1);
      check("push-pull swap", {4'h0, wave}, {4'h0, ~w1});
      // Overrides act in steering modes only.
      reg_wr(`CWU_OFS_CON1, 8'h03);
      reg_wr(`CWU_OFS_STR, 8'h50);
      reg_wr(`CWU_OFS_CON0, 8'h80);
      drive_d(1'b1);
      check("override", {4'h0, wave}, 8'h05);
      reg_wr(`CWU_OFS_CON0, 8'h82);
      drive_d(1'b1);
      check("override ignored", {4'h0, wave}, 8'h0A);
      // Counts load at once while disabled.
      reg_wr(`CWU_OFS_CON0, 8'h02);
      reg_wr(`CWU_OFS_DBR, 8'h15);
      reg_wr(`CWU_OFS_DBF, 8'h2A);
      // Let the count written at this edge settle before it is looked at.
      #1;
      check("rise direct", {2'b00, db_rise}, 8'h15);
      check("fall direct", {2'b00, db_fall}, 8'h2A);
      // A load request in the enabling write is dropped.
      reg_wr(`CWU_OFS_CON0, 8'hC2);
      reg_rd(`CWU_OFS_CON0, rv);
      check("load with enable", rv, 8'h82);
      reg_wr(`CWU_OFS_DBR, 8'h07);
      reg_wr(`CWU_OFS_DBF, 8'h09);
      drive_d(1'b0);
      drive_d(1'b1);
      check("held while enabled", {2'b00, db_rise}, 8'h15);
      // Load waits for a fall, then transfers on the next rise.
      reg_wr(`CWU_OFS_CON0, 8'hC2);
      reg_rd(`CWU_OFS_CON0, rv);
      check("load pending", rv, 8'hC2);
      drive_d(1'b0);
      check("no load on fall", {2'b00, db_fall}, 8'h2A);
      drive_d(1'b1);
      check("rise loaded", {2'b00, db_rise}, 8'h07);
      check("fall loaded", {2'b00, db_fall}, 8'h09);
      reg_rd(`CWU_OFS_CON0, rv);
      check("load cleared", rv, 8'h82);
      give_verdict();
   end
endmodule // testbench

`default_nettype wire
